// ### cmcs_adc_model.sv
// model: converter that hands the block one raw code per conversion
`timescale 1ns/1ps
module cmcs_adc_model (
    // clock
    input  wire logic clk,
    // converter output
    output logic        adc_valid,
    output logic [11:0] adc_code
);
    initial begin
        adc_valid = 1'h0;
        adc_code  = 12'hA5A;
    end
    // code lines are not held after the strobe: show the inverse so stale use fails
    task automatic convert(input logic [11:0] c);
        @(negedge clk);
        adc_valid = 1'h1;
        adc_code  = c;
        @(negedge clk);
        adc_valid = 1'h0;
        adc_code  = ~c;
    endtask
endmodule // cmcs_adc_model

// ### cmcs_code_if.sv
// interface: one 12-bit code and its polarity for word conversion
`timescale 1ns/1ps
interface cmcs_code_if;
    logic        polarity;
    logic [11:0] code;
    logic [15:0] word;
    modport user (output polarity, output code, input word);
    modport conv (input polarity, input code, output word);
endinterface

// ### cmcs_code_word.sv
// leaf: packs a 12-bit converter code into a 16-bit word
`timescale 1ns/1ps
module cmcs_code_word
    import cmcs_pkg::*;
(
    // code side
    cmcs_code_if.conv cw
);
    wire sign_fill = (cw.polarity == CMCS_POL_BIPOLAR) & cw.code[CMCS_SIGN_BIT];
    // bipolar sign-extends bit 11, unipolar zero-fills
    assign cw.word = {{(CMCS_WORD_W - CMCS_CODE_W){sign_fill}}, cw.code};
endmodule // cmcs_code_word

// ### cmcs_pkg.sv
// package: constants and types for converter mode and code select
package cmcs_pkg;
    // input modes, gray order along the usual path
    typedef enum logic [1:0] {
        CMCS_REFERENCED_SINGLE_ENDED      = 2'h0,
        CMCS_FLOATING_COMMON_SINGLE_ENDED = 2'h1,
        CMCS_PAIRED_CHANNEL_INPUT         = 2'h3
    } cmcs_mode_e;

    localparam logic       CMCS_POL_BIPOLAR   = 1'h0;
    localparam logic       CMCS_POL_UNIPOLAR  = 1'h1;
    localparam cmcs_mode_e CMCS_MODE_RST      = CMCS_REFERENCED_SINGLE_ENDED;
    localparam logic       CMCS_AI_POL_RST    = CMCS_POL_BIPOLAR;
    localparam logic       CMCS_AO_POL_RST    = CMCS_POL_BIPOLAR;
    localparam int         CMCS_CODE_W        = 12;
    localparam int         CMCS_WORD_W        = 16;
    localparam int         CMCS_SIGN_BIT      = 11;
    localparam int         CMCS_AO_CHANNELS   = 2;
    localparam int         CMCS_SE_CHANNELS   = 8;
    localparam int         CMCS_PAIR_CHANNELS = 4;
    localparam logic [15:0] CMCS_BIP_MIN      = 16'hF800;
    localparam logic [15:0] CMCS_BIP_MAX      = 16'h07FF;
    localparam logic [15:0] CMCS_UNI_MAX      = 16'h0FFF;
endpackage

// ### cmcs_top.sv
// top: converter input mode, multiplexer routing and code selection
// Operation
// - reset gives referenced single-ended, bipolar input
// - bipolar input codes are two's complement
// - unipolar input codes are straight binary
// - three modes; eight or four channels
// - paired mode routes even positive, odd negative
// - referenced mode grounds sense pin, negative input
// - floating mode uses sense pin, ungrounded
// - each output channel polarity; bipolar two's complement
// - unipolar output accepts 0 to FFF
// - output channel polarity resets to bipolar
`timescale 1ns/1ps
module cmcs_top
    import cmcs_pkg::*;
#(
    parameter int AO_N = CMCS_AO_CHANNELS
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // configuration
    input  wire logic              cfg_we,
    input  wire logic [1:0]        cfg_mode,
    input  wire logic              cfg_ai_pol,
    input  wire logic [AO_N-1:0]   cfg_ao_pol,
    input  wire logic [2:0]        chan_sel,
    // converter input
    input  wire logic              adc_valid,
    input  wire logic [11:0]       adc_code,
    // output channel writes
    input  wire logic [AO_N-1:0]   ao_we,
    input  wire logic [15:0]       ao_wdata,
    // status
    output logic [1:0]             mode_ff,
    output logic                   ai_pol_ff,
    output logic [AO_N-1:0]        ao_pol_ff,
    output logic                   chan_err_ff,
    // multiplexer control
    output logic [7:0]             mux_pos_ff,
    output logic [7:0]             mux_neg_ff,
    output logic                   neg_to_sense_ff,
    output logic                   sense_gnd_ff,
    // sample word
    output logic                   sample_valid_ff,
    output logic [15:0]            sample_ff,
    // output channel codes
    output logic [AO_N*12-1:0]     ao_code_ff,
    output logic [AO_N-1:0]        ao_range_err_ff
);
    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    cmcs_mode_e mode_e;
    // an illegal mode code falls back to the reset mode
    wire        mode_ok  = (cfg_mode == CMCS_REFERENCED_SINGLE_ENDED)
                         | (cfg_mode == CMCS_FLOATING_COMMON_SINGLE_ENDED)
                         | (cfg_mode == CMCS_PAIRED_CHANNEL_INPUT);
    wire [1:0]  nxt_mode = !rst_n ? CMCS_MODE_RST :
                           (cfg_we ? (mode_ok ? cfg_mode : CMCS_MODE_RST) : mode_ff);
    assign mode_e = cmcs_mode_e'(mode_ff);

    always_ff @(posedge clk) begin
        mode_ff <= nxt_mode;
        if (!rst_n) begin
            ai_pol_ff <= CMCS_AI_POL_RST;
            ao_pol_ff <= {AO_N{CMCS_AO_POL_RST}};
        end else if (cfg_we) begin
            ai_pol_ff <= cfg_ai_pol;
            ao_pol_ff <= cfg_ao_pol;
        end
    end

    // ------------------------------------------------------------
    // multiplexer routing
    // ------------------------------------------------------------
    logic [7:0] nxt_pos;
    logic [7:0] nxt_neg;
    logic       nxt_to_sense;
    logic       nxt_gnd;
    logic       nxt_cerr;
    // a pair select above three is refused and leaves the amplifier open
    wire        pair_bad = chan_sel[2];
    wire [2:0]  pair_even = {chan_sel[1:0], 1'h0};

    always_comb begin
        nxt_pos      = 8'h00;
        nxt_neg      = 8'h00;
        nxt_to_sense = 1'h0;
        nxt_gnd      = 1'h0;
        nxt_cerr     = 1'h0;
        unique case (mode_e)
            CMCS_REFERENCED_SINGLE_ENDED: begin
                nxt_pos      = 8'h01 << chan_sel;
                nxt_to_sense = 1'h1;
                nxt_gnd      = 1'h1;
            end
            CMCS_FLOATING_COMMON_SINGLE_ENDED: begin
                nxt_pos      = 8'h01 << chan_sel;
                nxt_to_sense = 1'h1;
                nxt_gnd      = 1'h0;
            end
            CMCS_PAIRED_CHANNEL_INPUT: begin
                nxt_cerr = pair_bad;
                if (!pair_bad) begin
                    nxt_pos = 8'h01 << pair_even;
                    nxt_neg = 8'h02 << pair_even;
                end
            end
            default: begin
                nxt_pos = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mux_pos_ff      <= 8'h00;
            mux_neg_ff      <= 8'h00;
            neg_to_sense_ff <= 1'h1;
            sense_gnd_ff    <= 1'h1;
            chan_err_ff     <= 1'h0;
        end else begin
            mux_pos_ff      <= nxt_pos;
            mux_neg_ff      <= nxt_neg;
            neg_to_sense_ff <= nxt_to_sense;
            sense_gnd_ff    <= nxt_gnd;
            chan_err_ff     <= nxt_cerr;
        end
    end

    // ------------------------------------------------------------
    // input sample coding
    // ------------------------------------------------------------
    cmcs_code_if ai_if ();
    assign ai_if.polarity = ai_pol_ff;
    assign ai_if.code     = adc_code;
    cmcs_code_word u_ai_word (
        .cw (ai_if.conv)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sample_valid_ff <= 1'h0;
            sample_ff       <= 16'h0000;
        end else begin
            sample_valid_ff <= adc_valid;
            if (adc_valid) begin
                sample_ff <= ai_if.word;
            end
        end
    end

    // ------------------------------------------------------------
    // output channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < AO_N; g++) begin : g_ao
            // bipolar takes 16-bit two's complement in F800..07FF, unipolar 0..0FFF
            wire bip    = (ao_pol_ff[g] == CMCS_POL_BIPOLAR);
            wire bip_ok = (ao_wdata >= CMCS_BIP_MIN) | (ao_wdata <= CMCS_BIP_MAX);
            wire uni_ok = (ao_wdata <= CMCS_UNI_MAX);
            wire ok     = bip ? bip_ok : uni_ok;
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ao_code_ff[g*12 +: 12] <= 12'h000;
                    ao_range_err_ff[g]     <= 1'h0;
                end else if (ao_we[g]) begin
                    ao_range_err_ff[g] <= !ok;
                    // out-of-range words are refused so the output never wraps
                    if (ok) begin
                        ao_code_ff[g*12 +: 12] <= ao_wdata[11:0];
                    end
                end
            end

            // a refused word must leave the stored code alone
            AST_AO_UNI: assert property (@(posedge clk) disable iff (!rst_n)
                ao_we[g] && ao_pol_ff[g] == CMCS_POL_UNIPOLAR && ao_wdata > CMCS_UNI_MAX
                |=> ao_range_err_ff[g] && $stable(ao_code_ff[g*12 +: 12]))
                else $error("unipolar out of range word accepted");
            AST_AO_BIP: assert property (@(posedge clk) disable iff (!rst_n)
                ao_we[g] && ao_pol_ff[g] == CMCS_POL_BIPOLAR && ao_wdata == CMCS_BIP_MIN
                |=> !ao_range_err_ff[g] && ao_code_ff[g*12 +: 12] == CMCS_BIP_MIN[11:0])
                else $error("bipolar minimum rejected");
            AST_AO_BIP_TOP: assert property (@(posedge clk) disable iff (!rst_n)
                ao_we[g] && ao_pol_ff[g] == CMCS_POL_BIPOLAR && ao_wdata == CMCS_BIP_MAX
                |=> !ao_range_err_ff[g] && ao_code_ff[g*12 +: 12] == CMCS_BIP_MAX[11:0])
                else $error("bipolar maximum rejected");
            AST_AO_BIP_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
                ao_we[g] && ao_pol_ff[g] == CMCS_POL_BIPOLAR
                && ao_wdata < CMCS_BIP_MIN && ao_wdata > CMCS_BIP_MAX
                |=> ao_range_err_ff[g] && $stable(ao_code_ff[g*12 +: 12]))
                else $error("bipolar out of range word accepted");
            AST_AO_UNI_ACCEPT: assert property (@(posedge clk) disable iff (!rst_n)
                ao_we[g] && ao_pol_ff[g] == CMCS_POL_UNIPOLAR && ao_wdata <= CMCS_UNI_MAX
                |=> !ao_range_err_ff[g] && ao_code_ff[g*12 +: 12] == $past(ao_wdata[11:0]))
                else $error("unipolar in range word refused");
            // code and error flag change only on a write to this channel
            AST_AO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
                !ao_we[g]
                |=> $stable(ao_code_ff[g*12 +: 12]) && $stable(ao_range_err_ff[g]))
                else $error("output channel changed without a write");
        end
    endgenerate

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_RESET_DEFAULTS: assert property (@(posedge clk)
        !rst_n |=> mode_ff == CMCS_MODE_RST && ai_pol_ff == CMCS_POL_BIPOLAR)
        else $error("reset defaults wrong");
    AST_AO_RESET: assert property (@(posedge clk)
        !rst_n |=> ao_pol_ff == {AO_N{CMCS_POL_BIPOLAR}})
        else $error("output polarity not bipolar after reset");
    AST_BIP_SIGN: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && ai_pol_ff == CMCS_POL_BIPOLAR && $stable(ai_pol_ff)
        |=> sample_ff == {{4{$past(adc_code[11])}}, $past(adc_code)})
        else $error("bipolar sample not sign extended");
    AST_UNI_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && ai_pol_ff == CMCS_POL_UNIPOLAR
        |=> sample_ff == {4'h0, $past(adc_code)})
        else $error("unipolar sample not zero filled");
    AST_PAIR_ROUTE: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_PAIRED_CHANNEL_INPUT && !chan_sel[2]
        |=> mux_neg_ff == (mux_pos_ff << 1) && (mux_pos_ff & 8'hAA) == 8'h00)
        else $error("pair routing wrong");
    AST_PAIR_LIMIT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_PAIRED_CHANNEL_INPUT && chan_sel[2]
        |=> chan_err_ff && mux_pos_ff == 8'h00)
        else $error("pair select above three accepted");
    AST_REF_GND: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_REFERENCED_SINGLE_ENDED
        |=> neg_to_sense_ff && sense_gnd_ff && mux_neg_ff == 8'h00)
        else $error("referenced mode not grounded");
    AST_FLOAT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_FLOATING_COMMON_SINGLE_ENDED
        |=> neg_to_sense_ff && !sense_gnd_ff)
        else $error("floating mode grounded");

    // ------------------------------------------------------------
    // configuration checks
    // ------------------------------------------------------------
    AST_CFG_LOAD: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_we && mode_ok
        |=> mode_ff == $past(cfg_mode) && ai_pol_ff == $past(cfg_ai_pol)
            && ao_pol_ff == $past(cfg_ao_pol))
        else $error("configuration write not loaded");
    AST_MODE_FALLBACK: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_we && !mode_ok
        |=> mode_ff == CMCS_MODE_RST)
        else $error("illegal mode code not refused");
    // settings stand until software writes them again
    AST_CFG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg_we
        |=> $stable(mode_ff) && $stable(ai_pol_ff) && $stable(ao_pol_ff))
        else $error("configuration changed without a write");
    AST_MODE_LEGAL: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff != 2'h2)
        else $error("illegal mode code held");

    // ------------------------------------------------------------
    // routing checks
    // ------------------------------------------------------------
    AST_PAIR_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_PAIRED_CHANNEL_INPUT && !chan_sel[2]
        |=> mux_pos_ff == (8'h01 << {$past(chan_sel[1:0]), 1'h0})
            && mux_neg_ff == (8'h02 << {$past(chan_sel[1:0]), 1'h0}))
        else $error("pair select routes the wrong channels");
    // the odd channel is the return path, so the sense pin stays off the amplifier
    AST_PAIR_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_PAIRED_CHANNEL_INPUT
        |=> !neg_to_sense_ff && !sense_gnd_ff)
        else $error("paired mode uses the sense pin");
    AST_SE_SELECT: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff != CMCS_PAIRED_CHANNEL_INPUT
        |=> mux_pos_ff == (8'h01 << $past(chan_sel)) && !chan_err_ff)
        else $error("single-ended select routes the wrong channel");
    AST_FLOAT_NEG: assert property (@(posedge clk) disable iff (!rst_n)
        mode_ff == CMCS_FLOATING_COMMON_SINGLE_ENDED
        |=> mux_neg_ff == 8'h00)
        else $error("floating mode drives a negative channel");
    AST_ROUTE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n)
        $onehot0(mux_pos_ff) && $onehot0(mux_neg_ff))
        else $error("more than one channel routed");

    // ------------------------------------------------------------
    // sample checks
    // ------------------------------------------------------------
    AST_SAMPLE_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid
        |=> sample_valid_ff)
        else $error("sample strobe lost");
    AST_SAMPLE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
        !adc_valid
        |=> !sample_valid_ff && $stable(sample_ff))
        else $error("sample changed without a conversion");
    // whatever the polarity, the top nibble copies bit eleven or is zero
    AST_SAMPLE_TOP: assert property (@(posedge clk) disable iff (!rst_n)
        sample_valid_ff
        |-> sample_ff[15:12] == {4{sample_ff[11]}} || sample_ff[15:12] == 4'h0)
        else $error("sample top bits not an extension");
endmodule // cmcs_top

// ### cmcs_top_bench.sv
// bench: self-checking run of converter mode and code select
`timescale 1ns/1ps
module cmcs_top_bench;
    import cmcs_pkg::*;
    logic        clk, rst_n, cfg_we, cfg_ai_pol, adc_valid, ai_pol_ff, chan_err_ff;
    logic        neg_to_sense_ff, sense_gnd_ff, sample_valid_ff;
    logic [1:0]  cfg_mode, cfg_ao_pol, ao_we, mode_ff, ao_pol_ff, ao_range_err_ff;
    logic [2:0]  chan_sel;
    logic [7:0]  mux_pos_ff, mux_neg_ff;
    logic [11:0] adc_code;
    logic [15:0] ao_wdata, sample_ff;
    logic [23:0] ao_code_ff;
    int          fail_count, checked;

    cmcs_top #(.AO_N(2)) cmcs_top_inst (.clk, .rst_n, .cfg_we, .cfg_mode, .cfg_ai_pol,
        .cfg_ao_pol, .chan_sel, .adc_valid, .adc_code, .ao_we, .ao_wdata, .mode_ff,
        .ai_pol_ff, .ao_pol_ff, .chan_err_ff, .mux_pos_ff, .mux_neg_ff, .neg_to_sense_ff,
        .sense_gnd_ff, .sample_valid_ff, .sample_ff, .ao_code_ff, .ao_range_err_ff);
    cmcs_adc_model cmcs_adc_model_inst (.clk, .adc_valid, .adc_code);

    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end
    // about 80 cycles are needed; allow 25 times that
    initial begin
        #50000;
        fail_count++;
        test_done();
    end

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rst_chk();
        @(negedge clk);
        rst_n = 1'h0;
        repeat (3) @(negedge clk);
        rst_n = 1'h1;
        chk("cfg", 16'h0, {11'h0, mode_ff, ai_pol_ff, ao_pol_ff});
        chk("sense", 16'h3, {14'h0, neg_to_sense_ff, sense_gnd_ff});
        chk("rst_mux", 16'h0, {mux_pos_ff, mux_neg_ff});
        chk("rst_smp", 16'h0, sample_ff);
        chk("rst_ao", 16'h0, {2'h0, ao_range_err_ff, ao_code_ff[23:12]});
        $display("reset done");
    endtask
    task automatic cfg(input logic [1:0] m, input logic p, input logic [1:0] o,
                       input logic [2:0] c);
        @(negedge clk);
        cfg_we     = 1'h1;
        cfg_mode   = m;
        cfg_ai_pol = p;
        cfg_ao_pol = o;
        chan_sel   = c;
        @(negedge clk);
        cfg_we = 1'h0;
        @(negedge clk);
    endtask
    task automatic mux(input logic [1:0] m, e, input logic [2:0] c, input logic [15:0] pn,
                       input logic [2:0] f);
        cfg(m, 1'h0, 2'h0, c);
        // paired mode leaves the sense pin off the amplifier and ungrounded
        chk("mode", {14'h0, e}, {14'h0, mode_ff});
        chk("mux", pn, {mux_pos_ff, mux_neg_ff});
        chk("flags", {13'h0, f}, {13'h0, neg_to_sense_ff, sense_gnd_ff, chan_err_ff});
        $display("mux done");
    endtask
    task automatic sweep(input logic [1:0] m, input int n);
        cfg(m, 1'h0, 2'h0, 3'h0);
        for (int i = 0; i < n; i++) begin
            chan_sel = 3'(i);
            @(negedge clk);
            chk("pos", {8'h0, 8'h01 << (n == 4 ? 2 * i : i)}, {8'h0, mux_pos_ff});
            chk("neg", {8'h0, n == 4 ? 8'h02 << (2 * i) : 8'h00}, {8'h0, mux_neg_ff});
        end
        $display("sweep done");
    endtask
    task automatic smp(input logic [11:0] c, input logic [15:0] e);
        cmcs_adc_model_inst.convert(c);
        chk("valid", 16'h1, {15'h0, sample_valid_ff});
        chk("sample", e, sample_ff);
        $display("sample done");
    endtask
    task automatic ao(input int g, input logic [15:0] d, input logic [11:0] c, input logic r);
        @(negedge clk);
        ao_we    = 2'(1 << g);
        ao_wdata = d;
        @(negedge clk);
        ao_we = 2'h0;
        chk("ao_code", {4'h0, c}, {4'h0, ao_code_ff[g*12+:12]});
        chk("ao_err", {15'h0, r}, {15'h0, ao_range_err_ff[g]});
        $display("ao done");
    endtask

    initial begin
        {rst_n, cfg_we, cfg_ai_pol, cfg_mode, cfg_ao_pol, ao_we, chan_sel} = '0;
        ao_wdata   = 16'h0;
        fail_count = 0;
        checked    = 0;
        rst_chk();
        mux(2'h3, 2'h3, 3'h2, 16'h1020, 3'h0);
        mux(2'h3, 2'h3, 3'h4, 16'h0000, 3'h1);
        mux(2'h0, 2'h0, 3'h7, 16'h8000, 3'h6);
        mux(2'h1, 2'h1, 3'h0, 16'h0100, 3'h4);
        mux(2'h2, 2'h0, 3'h3, 16'h0800, 3'h6);
        sweep(2'h0, 8);
        sweep(2'h1, 8);
        sweep(2'h3, 4);
        smp(12'h800, 16'hF800);
        smp(12'h7FF, 16'h07FF);
        ao(1, 16'hF800, 12'h800, 1'h0);
        ao(1, 16'h0FFF, 12'h800, 1'h1);
        cfg(2'h0, 1'h1, 2'h2, 3'h0);
        chk("pol", 16'h6, {13'h0, ai_pol_ff, ao_pol_ff});
        smp(12'hFFF, 16'h0FFF);
        smp(12'h800, 16'h0800);
        ao(1, 16'h0FFF, 12'hFFF, 1'h0);
        ao(1, 16'h1000, 12'hFFF, 1'h1);
        ao(0, 16'h07FF, 12'h7FF, 1'h0);
        ao(0, 16'h0800, 12'h7FF, 1'h1);
        ao(0, 16'hF7FF, 12'h7FF, 1'h1);
        $display("coding done");
        rst_chk();
        test_done();
    end
endmodule // cmcs_top_bench
